// ===== asram_host.sv
// asram_host.sv: host controller for a 128k x 8 asynchronous sram
// assumes the sram pins are wired straight out; data input is a pin
`timescale 1ns/1ps
`include "asram_defines.svh"
module asram_host #(
  parameter int ADDR_W = `ASRAM_ADDR_W,
  parameter int DATA_W = `ASRAM_DATA_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // user request
  input wire logic req_valid,
  input wire logic req_write,
  input wire asram_pkg::asram_addr_t req_addr,
  input wire asram_pkg::asram_data_t req_wdata,
  output logic req_ready,
  // user answer
  output logic rsp_valid,
  output asram_pkg::asram_data_t rsp_rdata,
  // retention control
  input wire logic retain_req,
  output logic retain_ok,
  // memory pins
  output asram_pkg::asram_addr_t word_address_lines,
  output logic select_primary_n,
  output logic select_secondary,
  output logic write_strobe_n,
  output logic output_gate_n,
  input wire asram_pkg::asram_data_t data_lines_in,
  output asram_pkg::asram_data_t data_lines_out,
  output logic data_lines_oe
);
  import asram_pkg::*;
  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  // read: address and gate to data valid, then sampled via 2 flops
  localparam int RD_CYC = `ASRAM_CYC_UP(`ASRAM_READ_CYCLE_NS);
  localparam int AA_CYC = `ASRAM_CYC_UP(`ASRAM_ADDR_ACCESS_NS);
  localparam int SAMP_CYC = (AA_CYC > RD_CYC ? AA_CYC : RD_CYC) + 2;
  localparam int FLT_CYC = `ASRAM_CYC_UP(`ASRAM_GATE_FLOAT_NS);
  localparam int WP_CYC = `ASRAM_CYC_UP(`ASRAM_STROBE_NS);
  localparam int CW_CYC = `ASRAM_CYC_UP(`ASRAM_SEL_WRITE_END_NS);
  localparam int DW_CYC = `ASRAM_CYC_UP(`ASRAM_DATA_SETUP_NS);
  localparam int WC_CYC = `ASRAM_CYC_UP(`ASRAM_WRITE_CYCLE_NS);
  // strobe low length covers pulse, select overlap and data setup
  localparam int WL0 = WP_CYC > CW_CYC ? WP_CYC : CW_CYC;
  localparam int WL_CYC = WL0 > DW_CYC ? WL0 : DW_CYC;
  // write phase plus the cycle in which the timer reads zero must reach the cycle time
  localparam int WR_LEN = (WL_CYC + 1) > WC_CYC ? WL_CYC : WC_CYC - 1;
  // refuse widths and counts that the logic cannot serve
  if (ADDR_W != `ASRAM_ADDR_W || DATA_W != `ASRAM_DATA_W) begin : g_bad_w
    $error("asram_host: widths must match the memory");
  end
  if (SAMP_CYC > 255 || WR_LEN > 255) begin : g_bad_cnt
    $error("asram_host: timer too narrow");
  end
  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  asram_data_t dq_meta; // first flop, read only by dq_sync
  asram_data_t dq_sync;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
    end else begin
      dq_meta <= data_lines_in;
      dq_sync <= dq_meta;
    end
  end
  // ---------------------------------------------------------------
  // timer
  // ---------------------------------------------------------------
  asram_cnt_if cnt ();
  asram_timer u_timer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .cnt(cnt)
  );
  // ---------------------------------------------------------------
  // access state machine
  // ---------------------------------------------------------------
  asram_state_e state, next_state;
  logic sel, next_sel; // both selects active
  logic we, next_we; // strobe active
  logic oe, next_oe; // gate active
  logic sel_n, next_sel_n; // primary select pin copy, active low
  logic we_n, next_we_n; // strobe pin copy, active low
  logic oe_n, next_oe_n; // gate pin copy, active low
  logic drv, next_drv; // host drives data lines
  logic rdy, next_rdy;
  logic rv, next_rv;
  logic ret, next_ret;
  asram_addr_t addr, next_addr;
  asram_data_t wd, next_wd;
  asram_data_t rd, next_rd;
  always_comb begin
    next_state = state;
    next_sel = sel;
    next_we = we;
    next_oe = oe;
    next_drv = drv;
    next_rdy = 1'b0;
    next_rv = 1'b0;
    next_ret = ret;
    next_addr = addr;
    next_wd = wd;
    next_rd = rd;
    cnt.load = 1'b0;
    cnt.value = 8'h00;
    unique case (state)
      ASRAM_IDLE: begin
        next_sel = 1'b0;
        next_ret = retain_req;
        if (ret && !retain_req) begin
          // supply back: wait one read cycle first, still deselected
          next_ret = 1'b1;
          cnt.load = 1'b1;
          cnt.value = RD_CYC[7:0];
          next_state = ASRAM_REC;
        end else if (!retain_req && !ret && req_valid && rdy) begin
          next_addr = req_addr;
          next_sel = 1'b1;
          next_rdy = 1'b0;
          cnt.load = 1'b1;
          if (req_write) begin
            next_wd = req_wdata;
            next_drv = 1'b1;
            next_we = 1'b1;
            cnt.value = WR_LEN[7:0];
            next_state = ASRAM_WRITE;
          end else begin
            next_oe = 1'b1;
            cnt.value = SAMP_CYC[7:0];
            next_state = ASRAM_READ;
          end
        end else begin
          next_rdy = !retain_req && !ret;
        end
      end
      ASRAM_READ: begin
        if (cnt.done) begin
          next_rd = dq_sync;
          next_rv = 1'b1;
          next_oe = 1'b0;
          next_sel = 1'b0;
          cnt.load = 1'b1;
          cnt.value = FLT_CYC[7:0];
          next_state = ASRAM_FLOAT;
        end
      end
      ASRAM_WRITE: begin
        if (cnt.done) begin
          // strobe and primary select rise as secondary select falls; data held two more cycles
          next_we = 1'b0;
          next_sel = 1'b0;
          cnt.load = 1'b1;
          cnt.value = 8'h01;
          next_state = ASRAM_FLOAT;
        end
      end
      ASRAM_FLOAT: begin
        if (cnt.done) begin
          next_drv = 1'b0;
          next_state = ASRAM_IDLE;
        end
      end
      ASRAM_REC: begin
        if (cnt.done) begin
          next_ret = 1'b0;
          next_state = ASRAM_IDLE;
        end
      end
      default: next_state = ASRAM_IDLE;
    endcase
    // active-low pin copies, so each pin leaves a flop directly
    next_sel_n = !next_sel;
    next_we_n = !next_we;
    next_oe_n = !next_oe;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ASRAM_IDLE;
      sel <= 1'b0;
      we <= 1'b0;
      oe <= 1'b0;
      sel_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      drv <= 1'b0;
      rdy <= 1'b0;
      rv <= 1'b0;
      ret <= 1'b0;
      addr <= 17'h00000;
      wd <= 8'h00;
      rd <= 8'h00;
    end else begin
      state <= next_state;
      sel <= next_sel;
      we <= next_we;
      oe <= next_oe;
      sel_n <= next_sel_n;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      drv <= next_drv;
      rdy <= next_rdy;
      rv <= next_rv;
      ret <= next_ret;
      addr <= next_addr;
      wd <= next_wd;
      rd <= next_rd;
    end
  end
  // ---------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------
  assign word_address_lines = addr;
  assign select_primary_n = sel_n;
  assign select_secondary = sel;
  assign write_strobe_n = we_n;
  assign output_gate_n = oe_n;
  assign data_lines_out = wd;
  assign data_lines_oe = drv;
  assign req_ready = rdy;
  assign rsp_valid = rv;
  assign rsp_rdata = rd;
  assign retain_ok = ret;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_write_needs_sel: assert property (@(posedge clk_sys) disable iff (!arst_n)
    we |-> sel) else $error("strobe low without selects");
  a_no_fight: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(drv && oe)) else $error("host drives while gate low");
  a_strobe_width: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(we) |-> we [*4]) else $error("strobe too short");
  a_data_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(we) |-> drv && $stable(wd)) else $error("data lost at end");
  a_retain_desel: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ret |-> !sel) else $error("selected in retention");
  a_read_len: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(oe) |-> oe [*6]) else $error("read cycle too short");
  a_read_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(oe) |-> ##[6:12] rv) else $error("no read answer");
  a_addr_stable: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sel && $past(sel) |-> $stable(addr)) else $error("addr moved");
endmodule // asram_host

// ===== asram_defines.svh
// asram_defines.svh: timing counts and widths for the async sram host
// assumes a 100 MHz system clock (10 ns period)
`ifndef ASRAM_DEFINES_SVH
`define ASRAM_DEFINES_SVH
`define ASRAM_CLK_NS 10
`define ASRAM_ADDR_W 17
`define ASRAM_DATA_W 8
// fast grade times in ns
`define ASRAM_READ_CYCLE_NS 55
`define ASRAM_ADDR_ACCESS_NS 55
`define ASRAM_GATE_FLOAT_NS 20
`define ASRAM_WRITE_CYCLE_NS 55
`define ASRAM_SEL_WRITE_END_NS 45
`define ASRAM_STROBE_NS 40
`define ASRAM_DATA_SETUP_NS 25
// least times round up to whole cycles
`define ASRAM_CYC_UP(ns) (((ns) + `ASRAM_CLK_NS - 1) / `ASRAM_CLK_NS)
`endif

// ===== asram_pkg.sv
// asram_pkg.sv: types shared by the async sram host files
// assumes asram_defines.svh is reachable by include
`include "asram_defines.svh"
package asram_pkg;
  typedef logic [`ASRAM_ADDR_W-1:0] asram_addr_t;
  typedef logic [`ASRAM_DATA_W-1:0] asram_data_t;
  typedef enum logic [2:0] {
    ASRAM_IDLE = 3'b000,
    ASRAM_READ = 3'b001,
    ASRAM_WRITE = 3'b010,
    ASRAM_REC = 3'b011,
    ASRAM_FLOAT = 3'b100
  } asram_state_e;
endpackage

// ===== asram_cnt_if.sv
// asram_cnt_if.sv: load/expire handshake between fsm and its timer
// assumes one clock domain
`timescale 1ns/1ps
interface asram_cnt_if;
  logic load; // start a new count
  logic [7:0] value; // cycles to count
  logic done; // count reached zero
  modport fsm (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface

// ===== asram_timer.sv
// asram_timer.sv: cycle down counter for phase lengths
// assumes loads come from the same clock domain
`timescale 1ns/1ps
module asram_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // control
  asram_cnt_if.tmr cnt
);
  logic [7:0] count; // remaining cycles
  logic [7:0] next_count;
  // ---------------------------------------------------------------
  // next count
  // ---------------------------------------------------------------
  always_comb begin
    next_count = count;
    if (cnt.load) begin
      next_count = cnt.value;
    end else if (count != 8'h00) begin
      next_count = count - 8'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count <= 8'h00;
    end else begin
      count <= next_count;
    end
  end
  // done depends on the count alone: a term on load would close a loop
  // through the state machine, which loads in the cycle it sees done
  assign cnt.done = (count == 8'h00);
endmodule // asram_timer

// ===== asram_dev_model.sv
// asram_dev_model.sv: behavioural 128k x 8 asynchronous static memory
// assumes the host pins come straight in; the bench resolves data lines
`timescale 1ns/1ps
module asram_dev_model #(
  parameter int ACC_NS = 55 // answers as late as the access time allows
) (
  // memory pins
  input wire asram_pkg::asram_addr_t word_address_lines,
  input wire logic select_primary_n,
  input wire logic select_secondary,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire asram_pkg::asram_data_t data_lines,
  // model side
  output asram_pkg::asram_data_t mem_q,
  output logic mem_drive,
  output int viol
);
  import asram_pkg::*;
  asram_data_t mem [0:131071];
  logic sel; // both selects active
  logic wr; // write overlap
  logic [25:0] key; // what the read output depends on
  logic [25:0] key_dly; // same, seen only once stable
  realtime t_sel, t_wr, t_dat; // start of select, strobe, data
  // -------------------------------------------------------------
  // mode decode
  // -------------------------------------------------------------
  assign sel = !select_primary_n && select_secondary;
  assign wr = sel && !write_strobe_n;
  assign mem_drive = sel && write_strobe_n && !output_gate_n;
  assign key = {mem_drive, word_address_lines, mem[word_address_lines]};
  assign #(ACC_NS) key_dly = key;
  // junk (inverted byte) until the access time has run, and when floating
  assign mem_q = (mem_drive && key_dly === key) ?
    mem[word_address_lines] : ~mem[word_address_lines];
  // -------------------------------------------------------------
  // storage: changes only inside a write overlap
  // -------------------------------------------------------------
  always @* begin
    if (wr) begin
      mem[word_address_lines] = data_lines;
    end
  end
  // -------------------------------------------------------------
  // host timing watch at the end of each write
  // -------------------------------------------------------------
  initial viol = 0;
  always @(posedge sel) t_sel = $realtime;
  always @(posedge wr) t_wr = $realtime;
  always @(data_lines) t_dat = $realtime;
  always @(negedge wr) begin
    if ($realtime > 100.0) begin
      if ($realtime - t_wr < 40.0) viol++;
      if ($realtime - t_sel < 45.0) viol++;
      if ($realtime - t_dat < 25.0) viol++;
    end
  end
endmodule // asram_dev_model

// ===== asram_host_tb_top.sv
// asram_host_tb_top.sv: self-checking bench for the sram host
// assumes asram_dev_model stands on the pins; 100 MHz clock
`timescale 1ns/1ps
module asram_host_tb_top;
  import asram_pkg::*;
  logic clk_sys, arst_n, req_valid, req_write, retain_req;
  logic req_ready, rsp_valid, retain_ok, select_primary_n;
  logic select_secondary, write_strobe_n, output_gate_n;
  logic data_lines_oe, mem_drive;
  asram_addr_t req_addr, word_address_lines;
  asram_data_t req_wdata, rsp_rdata, data_lines_out, data_lines_in, mem_q;
  int viol, num_errors, n_checks, cyc;
  asram_data_t shadow [asram_addr_t]; // expected contents
  asram_addr_t keys [$]; // written addresses
  // -------------------------------------------------------------
  // design, memory model and shared lines
  // -------------------------------------------------------------
  assign data_lines_in = data_lines_oe ? data_lines_out : mem_q;
  asram_host dut_u (.clk_sys, .arst_n, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .retain_req,
    .retain_ok, .word_address_lines, .select_primary_n,
    .select_secondary, .write_strobe_n, .output_gate_n, .data_lines_in,
    .data_lines_out, .data_lines_oe);
  asram_dev_model mem_u (.word_address_lines, .select_primary_n,
    .select_secondary, .write_strobe_n, .output_gate_n,
    .data_lines(data_lines_in), .mem_q, .mem_drive, .viol);
  // -------------------------------------------------------------
  // compare and report
  // -------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one access; reads are compared against the shadow copy
  task automatic op(input logic w, input asram_addr_t a,
                    input asram_data_t d);
    int n;
    n = 0;
    // let an edge pass so valid is never driven twice in one step
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    // hold the request until ready is seen high at an edge
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    chk(req_ready, 1'b1);
    req_valid <= 1'b0;
    req_addr <= ~a;
    req_wdata <= ~d;
    if (w) shadow[a] = d;
    else begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (rsp_valid !== 1'b1 && n < 20);
      chk(rsp_valid, 1'b1);
      chk(rsp_rdata, shadow[a]);
    end
  endtask
  // -------------------------------------------------------------
  // clock, watchdog and per-cycle pin checks
  // -------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
    if (arst_n) begin
      chk(data_lines_oe & mem_drive, 1'b0);
      chk(!write_strobe_n & (select_primary_n | !select_secondary),
          1'b0);
    end
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    asram_addr_t a;
    asram_data_t d;
    int n;
    void'($urandom(32'ha54081fb));
    {arst_n, req_valid, req_write, retain_req} = 4'h0;
    req_addr = 17'h00000;
    req_wdata = 8'h00;
    {num_errors, n_checks, cyc} = 0;
    repeat (5) @(posedge clk_sys);
    chk({select_primary_n, select_secondary, data_lines_oe}, 3'h4);
    arst_n <= 1'b1;
    // corner addresses, then random write/read pairs back to back
    op(1'b1, 17'h00000, 8'h00);
    op(1'b1, 17'h1ffff, 8'hff);
    keys.push_back(17'h00000);
    keys.push_back(17'h1ffff);
    repeat (30) begin
      a = 17'($urandom);
      d = 8'($urandom);
      op(1'b1, a, d);
      op(1'b0, a, 8'h00);
      keys.push_back(a);
    end
    // retention: selects off, refused, then recovery wait
    retain_req <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (retain_ok !== 1'b1 && n < 20);
    repeat (3) @(posedge clk_sys);
    chk({retain_ok, select_primary_n, select_secondary, req_ready},
        4'hc);
    retain_req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    chk(n >= 6, 1'b1);
    // contents survive standby and other addresses' writes
    foreach (keys[i]) op(1'b0, keys[i], 8'h00);
    repeat (10) op(1'b0, keys[$urandom % keys.size()], 8'h00);
    chk(viol == 0, 1'b1);
    summarize();
  end
endmodule // asram_host_tb_top
